// ==== bsdp_params.sv ====
// battery switch and monitor diagnostic parameter bank on an AHB-Lite slave
`timescale 1ns/100ps
`include "bsdp_defs.svh"
module bsdp_params #(
  parameter int MON_CH = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic ring_valid_i,
  input wire logic signed [15:0] ring_voltage_i,
  input wire logic mon_valid_i,
  input wire logic [MON_CH*16-1:0] mon_data_i,
  output logic high_battery_sel_o,
  output logic signed [15:0] tracking_voltage_o,
  output logic [31:0] speedup_threshold_o,
  output logic [7:0] monitor_input_select_o
);
  bsdp_pkg::bsdp_word_t hth_reg, lth_reg, swc_reg, trc_reg, spl_reg, spu_reg;
  bsdp_pkg::bsdp_word_t rms_reg, rmc_reg, vov_reg;
  logic [7:0] sel_reg;
  logic [1:0] ctl_reg;
  bsdp_pkg::bsdp_bat_e bat_reg, bat_next;

  // bus pipeline: address phase captured, write applied in data phase
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic ap_take;
  logic [7:0] ap_idx;
  logic wr_en;
  bsdp_pkg::bsdp_word_t wd;

  function automatic logic coef_idx(input logic [7:0] i);
    coef_idx = (i == `BSDP_IDX_SWC) || (i == `BSDP_IDX_TRC) || (i == `BSDP_IDX_RMC);
  endfunction

  // stored view of a written word, reserved bits forced to zero
  function automatic bsdp_pkg::bsdp_word_t wmask(input logic [7:0] i,
                                                 input bsdp_pkg::bsdp_word_t d);
    wmask = d;
    if ((i == `BSDP_IDX_HTH) || (i == `BSDP_IDX_LTH)) begin
      wmask = '0;
      wmask[`BSDP_THR_MSB:`BSDP_THR_LSB] = d[`BSDP_THR_MSB:`BSDP_THR_LSB];
    end else if (coef_idx(i)) begin
      wmask[`BSDP_COEF_LSB-1:0] = '0;
    end
  endfunction

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [31:0] rem;
    logic [15:0] root;
    logic [17:0] trial;
    rem = '0;
    root = '0;
    for (int k = 15; k >= 0; k--) begin
      rem = {rem[29:0], v[2*k+1], v[2*k]};
      trial = {root, 2'b01};
      if (rem >= {14'h0000, trial}) begin
        rem = rem - {14'h0000, trial};
        root = {root[14:0], 1'b1};
      end else begin
        root = {root[14:0], 1'b0};
      end
    end
    isqrt = root;
  endfunction

  assign ap_take = hsel_i && hready_i && htrans_i[1];
  assign ap_idx = haddr_i[`BSDP_IDX_MSB:`BSDP_IDX_LSB];
  assign wr_en = wr_pend_reg;
  assign wd = hwdata_i[15:0];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= `BSDP_RST8;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      wr_pend_reg <= ap_take && hwrite_i && (hsize_i == 3'h2) && (haddr_i[1:0] == 2'h0);
      wr_idx_reg <= ap_idx;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // register file
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hth_reg <= `BSDP_RST16;
      lth_reg <= `BSDP_RST16;
      swc_reg <= `BSDP_RST16;
      trc_reg <= `BSDP_RST16;
      spl_reg <= `BSDP_RST16;
      spu_reg <= `BSDP_RST16;
      rmc_reg <= `BSDP_RST16;
      vov_reg <= `BSDP_RST16;
      sel_reg <= `BSDP_RST8;
      ctl_reg <= 2'h0;
    end else if (wr_en) begin
      case (wr_idx_reg)
        `BSDP_IDX_HTH: hth_reg <= wmask(wr_idx_reg, wd);
        `BSDP_IDX_LTH: lth_reg <= wmask(wr_idx_reg, wd);
        `BSDP_IDX_SWC: swc_reg <= wmask(wr_idx_reg, wd);
        `BSDP_IDX_TRC: trc_reg <= wmask(wr_idx_reg, wd);
        `BSDP_IDX_SPL: spl_reg <= wd;
        `BSDP_IDX_SPU: spu_reg <= wd;
        `BSDP_IDX_RMC: rmc_reg <= wmask(wr_idx_reg, wd);
        `BSDP_IDX_VOV: vov_reg <= wd;
        `BSDP_IDX_SEL: sel_reg <= hwdata_i[7:0];
        `BSDP_IDX_CTL: ctl_reg <= hwdata_i[1:0];
        default: ;
      endcase
    end
  end

  function automatic logic [31:0] rd_word(input logic [7:0] i);
    case (i)
      `BSDP_IDX_HTH: rd_word = {16'h0000, hth_reg};
      `BSDP_IDX_LTH: rd_word = {16'h0000, lth_reg};
      `BSDP_IDX_SWC: rd_word = {16'h0000, swc_reg};
      `BSDP_IDX_TRC: rd_word = {16'h0000, trc_reg};
      `BSDP_IDX_SPL: rd_word = {16'h0000, spl_reg};
      `BSDP_IDX_SPU: rd_word = {16'h0000, spu_reg};
      `BSDP_IDX_RMS: rd_word = {16'h0000, rms_reg};
      `BSDP_IDX_RMC: rd_word = {16'h0000, rmc_reg};
      `BSDP_IDX_VOV: rd_word = {16'h0000, vov_reg};
      `BSDP_IDX_SEL: rd_word = {24'h000000, sel_reg};
      `BSDP_IDX_CTL: rd_word = {30'h00000000, ctl_reg};
      `BSDP_IDX_STA: rd_word = {31'h00000000, bat_reg == bsdp_pkg::BSDP_BAT_HIGH};
      default: rd_word = 32'h00000000;
    endcase
  endfunction

  // read data loaded at the address phase; a write still in its data phase is forwarded, except one to the RMS result or the status word
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= 32'h00000000;
    end else if (ap_take && !hwrite_i) begin
      if (wr_en && (wr_idx_reg == ap_idx) && (ap_idx != `BSDP_IDX_RMS)
          && (ap_idx != `BSDP_IDX_STA)) begin
        if (ap_idx == `BSDP_IDX_SEL) begin
          hrdata_o <= {24'h000000, hwdata_i[7:0]};
        end else if (ap_idx == `BSDP_IDX_CTL) begin
          hrdata_o <= {30'h00000000, hwdata_i[1:0]};
        end else if (rd_word(ap_idx) == 32'h00000000 && !(coef_idx(ap_idx)
                     || ap_idx == `BSDP_IDX_HTH || ap_idx == `BSDP_IDX_LTH
                     || ap_idx == `BSDP_IDX_SPL || ap_idx == `BSDP_IDX_SPU
                     || ap_idx == `BSDP_IDX_VOV)) begin
          hrdata_o <= 32'h00000000;
        end else begin
          hrdata_o <= {16'h0000, wmask(ap_idx, wd)};
        end
      end else begin
        hrdata_o <= rd_word(ap_idx);
      end
    end
  end

  // RING voltage filters
  logic signed [15:0] ring_sw;
  bsdp_lpf #(.W(16)) u_sw_lpf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .valid_i(ring_valid_i),
    .x_i(ring_voltage_i),
    .coeff_i(swc_reg),
    .y_o(ring_sw)
  );

  bsdp_lpf #(.W(16)) u_trk_lpf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .valid_i(ring_valid_i && ctl_reg[`BSDP_CTL_TRACK]),
    .x_i(ring_voltage_i),
    .coeff_i(trc_reg),
    .y_o(tracking_voltage_o)
  );

  // switch level: magnitude of filtered RING plus overhead, signed
  logic signed [17:0] lvl;
  logic signed [17:0] thr_h, thr_l;
  always_comb begin
    lvl = (ring_sw[15] ? -{{2{ring_sw[15]}}, ring_sw} : {{2{ring_sw[15]}}, ring_sw})
          + {{2{vov_reg[15]}}, vov_reg};
    thr_h = {3'h0, hth_reg[`BSDP_THR_MSB:`BSDP_THR_LSB], 7'h00};
    thr_l = {3'h0, lth_reg[`BSDP_THR_MSB:`BSDP_THR_LSB], 7'h00};
    bat_next = bat_reg;
    if (ctl_reg[`BSDP_CTL_ACTIVE]) begin
      case (bat_reg)
        bsdp_pkg::BSDP_BAT_LOW:
          if (lvl > thr_h) bat_next = bsdp_pkg::BSDP_BAT_HIGH;
        bsdp_pkg::BSDP_BAT_HIGH:
          if (lvl < thr_l) bat_next = bsdp_pkg::BSDP_BAT_LOW;
        default: bat_next = bsdp_pkg::BSDP_BAT_LOW;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bat_reg <= bsdp_pkg::BSDP_BAT_LOW;
      high_battery_sel_o <= 1'b0;
      speedup_threshold_o <= 32'h00000000;
      monitor_input_select_o <= `BSDP_RST8;
    end else begin
      bat_reg <= bat_next;
      high_battery_sel_o <= (bat_next == bsdp_pkg::BSDP_BAT_HIGH);
      speedup_threshold_o <= {spu_reg, spl_reg};
      monitor_input_select_o <= sel_reg;
    end
  end

  // monitor channel, dc removal and mean square
  logic signed [15:0] mon_x, mon_dc;
  logic signed [16:0] mon_ac;
  logic [33:0] mon_sq;
  logic signed [33:0] mon_ms;
  logic mon_upd_reg;
  always_comb begin
    mon_x = 16'h0000;
    for (int c = 0; c < MON_CH; c++) begin
      if (sel_reg == 8'(c)) mon_x = mon_data_i[c*16 +: 16];
    end
    mon_ac = {mon_x[15], mon_x} - {mon_dc[15], mon_dc};
    mon_sq = 34'(mon_ac * mon_ac);
  end

  bsdp_lpf #(.W(16)) u_dc_lpf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .valid_i(mon_valid_i),
    .x_i(mon_x),
    .coeff_i(rmc_reg),
    .y_o(mon_dc)
  );

  bsdp_lpf #(.W(34)) u_ms_lpf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .valid_i(mon_valid_i),
    .x_i(mon_sq),
    .coeff_i(rmc_reg),
    .y_o(mon_ms)
  );

  // result: hardware update wins over a software write in the same cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mon_upd_reg <= 1'b0;
      rms_reg <= `BSDP_RST16;
    end else begin
      mon_upd_reg <= mon_valid_i;
      if (mon_upd_reg) begin
        rms_reg <= isqrt((mon_ms[33:32] != 2'h0) ? 32'hFFFFFFFF : mon_ms[31:0]);
      end else if (wr_en && (wr_idx_reg == `BSDP_IDX_RMS)) begin
        rms_reg <= wd;
      end
    end
  end

  a_bus_okay: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $past(reset_n_i) |-> hreadyout_o && !hresp_o)
    else $error("slave stalled or errored");
  a_high_switch: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (ctl_reg[0] && bat_reg == bsdp_pkg::BSDP_BAT_LOW && lvl > thr_h) |=> high_battery_sel_o)
    else $error("high battery not selected");
  a_low_switch: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (ctl_reg[0] && bat_reg == bsdp_pkg::BSDP_BAT_HIGH && lvl < thr_l) |=> !high_battery_sel_o)
    else $error("low battery not selected");
  a_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !ctl_reg[0] |=> $stable(bat_reg))
    else $error("battery changed outside active mode");
  a_speedup_join: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 speedup_threshold_o == {$past(spu_reg), $past(spl_reg)})
    else $error("speedup threshold mismatch");
  a_coeff_low: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_en && coef_idx(wr_idx_reg) |=> (swc_reg[2:0] | trc_reg[2:0] | rmc_reg[2:0]) == 3'h0)
    else $error("coefficient low bits kept");
  a_rms_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !mon_upd_reg && !(wr_en && wr_idx_reg == `BSDP_IDX_RMS) |=> $stable(rms_reg))
    else $error("rms result changed without cause");
  a_thr_store: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_en && wr_idx_reg == `BSDP_IDX_HTH |=> hth_reg == {1'b0, $past(wd[14:7]), 7'h00})
    else $error("high threshold not stored");
  a_sel_follow: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_en && wr_idx_reg == `BSDP_IDX_SEL |=> ##1 monitor_input_select_o == $past(hwdata_i[7:0], 2))
    else $error("monitor select not applied");
endmodule // bsdp_params

// ==== bsdp_defs.svh ====
// register indices, field positions and reset values of the battery switch parameter bank
`ifndef BSDP_DEFS_SVH
`define BSDP_DEFS_SVH
`define BSDP_IDX_HTH 8'h1F
`define BSDP_IDX_LTH 8'h20
`define BSDP_IDX_SWC 8'h21
`define BSDP_IDX_TRC 8'h22
`define BSDP_IDX_SPL 8'h23
`define BSDP_IDX_SPU 8'h24
`define BSDP_IDX_RMS 8'h35
`define BSDP_IDX_RMC 8'h36
`define BSDP_IDX_VOV 8'h05
`define BSDP_IDX_SEL 8'h40
`define BSDP_IDX_CTL 8'h41
`define BSDP_IDX_STA 8'h42
`define BSDP_IDX_MSB 9
`define BSDP_IDX_LSB 2
`define BSDP_THR_MSB 14
`define BSDP_THR_LSB 7
`define BSDP_COEF_LSB 3
`define BSDP_CTL_ACTIVE 0
`define BSDP_CTL_TRACK 1
`define BSDP_RST16 16'h0000
`define BSDP_RST8 8'h00
`define BSDP_MV_PER_LSB_X1000 4907
`define BSDP_RMS_MAX_HZ 300
`endif

// ==== bsdp_pkg.sv ====
// types shared by the battery switch parameter bank
package bsdp_pkg;
  typedef logic [15:0] bsdp_word_t;
  typedef enum logic [0:0] {
    BSDP_BAT_LOW = 1'b0,
    BSDP_BAT_HIGH = 1'b1
  } bsdp_bat_e;
endpackage

// ==== bsdp_lpf.sv ====
// first order low-pass filter with a 16-bit coefficient
`timescale 1ns/100ps
module bsdp_lpf #(
  parameter int W = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic valid_i,
  input wire logic signed [W-1:0] x_i,
  input wire logic [15:0] coeff_i,
  output logic signed [W-1:0] y_o
);
  logic signed [W:0] diff;
  logic signed [W+17:0] prod;
  logic signed [W:0] y_next;

  always_comb begin
    diff = {x_i[W-1], x_i} - {y_o[W-1], y_o};
    prod = diff * $signed({1'b0, coeff_i});
    y_next = {y_o[W-1], y_o} + prod[W+16:16];
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      y_o <= '0;
    end else if (valid_i) begin
      y_o <= y_next[W-1:0];
    end
  end
endmodule // bsdp_lpf

// ==== tb_battery_switch_diag_params.sv ====
// self-checking bench for the battery switch and monitor diagnostic parameter bank
`timescale 1ns/100ps
module tb_battery_switch_diag_params;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ring_valid = 1'b0;
  logic [15:0] ring_voltage = 16'h0;
  logic mon_valid = 1'b0;
  logic [63:0] mon_data = 64'h0;
  logic high_sel;
  logic [15:0] track_v;
  logic [31:0] speedup_thr;
  logic [7:0] mon_sel;
  int err_count = 0;
  int cmp_count = 0;
  integer seed = 7;
  logic [7:0] idx_list [13] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h35, 8'h36,
                                 8'h42, 8'h40, 8'h05, 8'h41, 8'h7E};
  logic [31:0] exp_val [13];
  logic [31:0] rd;
  logic [15:0] r;

  always #10 clk_sys = ~clk_sys;

  bsdp_params #(.MON_CH(4)) dut_u (
    .clk_sys_i(clk_sys), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .ring_valid_i(ring_valid), .ring_voltage_i(ring_voltage), .mon_valid_i(mon_valid),
    .mon_data_i(mon_data), .high_battery_sel_o(high_sel), .tracking_voltage_o(track_v),
    .speedup_threshold_o(speedup_thr), .monitor_input_select_o(mon_sel)
  );

  // bits that each location keeps; read-only and unmapped places read zero
  function automatic logic [31:0] fmask(input logic [7:0] idx);
    case (idx)
      8'h1F, 8'h20: fmask = 32'h0000_7F80;
      8'h21, 8'h22, 8'h36: fmask = 32'h0000_FFF8;
      8'h23, 8'h24, 8'h35, 8'h05: fmask = 32'h0000_FFFF;
      8'h40: fmask = 32'h0000_00FF;
      8'h41: fmask = 32'h0000_0003;
      default: fmask = 32'h0000_0000;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, idx, 32'h0);
    check(rd, lo, hi);
  endtask

  task automatic ring_feed(input logic [15:0] v, input int n);
    repeat (n) begin
      ring_valid <= 1'b1;
      ring_voltage <= v;
      @(posedge clk_sys);
      ring_valid <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask

  // square wave on channel 1, zero on every other channel
  task automatic mon_feed(input int n);
    for (int k = 0; k < n; k++) begin
      mon_valid <= 1'b1;
      mon_data <= {32'h0, (k % 2) ? 16'h0400 : 16'hFC00, 16'h0};
      @(posedge clk_sys);
      mon_valid <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic sel_chk(input logic e);
    check({31'h0, high_sel}, {31'h0, e}, {31'h0, e});
    rd_chk(8'h42, {31'h0, e}, {31'h0, e});
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 13; i++) rd_chk(idx_list[i], 32'h0, 32'h0);
    check(speedup_thr, 32'h0, 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 13; i++) begin
      exp_val[i] = $random(seed);
      // keep the switch inactive so the status location stays low
      if (idx_list[i] == 8'h41) exp_val[i][0] = 1'b0;
      bus(1'b1, idx_list[i], exp_val[i]);
      exp_val[i] = exp_val[i] & fmask(idx_list[i]);
    end
    for (int i = 0; i < 13; i++) rd_chk(idx_list[i], exp_val[i], exp_val[i]);
    rd = {exp_val[5][15:0], exp_val[4][15:0]};
    check(speedup_thr, rd, rd);
    check({24'h0, mon_sel}, {24'h0, exp_val[9][7:0]}, {24'h0, exp_val[9][7:0]});
    // a halfword write must not land
    hsize <= 3'h1;
    bus(1'b1, 8'h23, 32'h0000_1234);
    hsize <= 3'h2;
    rd_chk(8'h23, exp_val[4], exp_val[4]);
    $display("test register_access done");
    bus(1'b1, 8'h1F, 32'h0000_2000);
    bus(1'b1, 8'h20, 32'h0000_0800);
    bus(1'b1, 8'h21, 32'h0000_7FF8);
    bus(1'b1, 8'h05, 32'h0000_0000);
    bus(1'b1, 8'h41, 32'h0000_0001);
    ring_feed(16'h0100, 16);
    sel_chk(1'b0);
    r = 16'($random(seed)) & 16'h00FF;
    ring_feed(16'h1C00 + r, 16);
    sel_chk(1'b0);
    bus(1'b1, 8'h05, 32'h0000_0800);
    repeat (3) @(posedge clk_sys);
    sel_chk(1'b1);
    ring_feed(16'h0100 + r, 16);
    sel_chk(1'b1);
    bus(1'b1, 8'h05, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    sel_chk(1'b0);
    bus(1'b1, 8'h41, 32'h0000_0000);
    ring_feed(16'h3000, 16);
    sel_chk(1'b0);
    bus(1'b1, 8'h41, 32'h0000_0001);
    ring_feed(16'hD000 - r, 16);
    sel_chk(1'b1);
    $display("test battery_switch done");
    bus(1'b1, 8'h22, 32'h0000_7FFF);
    bus(1'b1, 8'h41, 32'h0000_0003);
    ring_feed(16'h0600, 16);
    check({16'h0, track_v}, 32'h0000_05F0, 32'h0000_0600);
    bus(1'b1, 8'h41, 32'h0000_0001);
    ring_feed(16'h0100, 16);
    check({16'h0, track_v}, 32'h0000_05F0, 32'h0000_0600);
    $display("test tracking_filter done");
    bus(1'b1, 8'h36, 32'h0000_0000);
    bus(1'b1, 8'h35, 32'h0000_0000);
    bus(1'b1, 8'h40, 32'h0000_0001);
    mon_feed(20);
    rd_chk(8'h35, 32'h0, 32'h0);
    bus(1'b1, 8'h36, 32'h0000_1007);
    bus(1'b1, 8'h40, 32'h0000_0000);
    mon_feed(20);
    rd_chk(8'h35, 32'h0, 32'h0);
    bus(1'b1, 8'h40, 32'h0000_0001);
    // select output follows the register one cycle later
    repeat (2) @(posedge clk_sys);
    check({24'h0, mon_sel}, 32'h0000_0001, 32'h0000_0001);
    mon_feed(200);
    rd_chk(8'h35, 32'h0000_0300, 32'h0000_0480);
    $display("test monitor_rms done");
    stop_test();
  end
endmodule // tb_battery_switch_diag_params
